// File: include/ppsh_pkg.sv
// package for the profile position set-point handler
package ppsh_pkg;

  // object indices of the two command words
  localparam logic [15:0] PPSH_IDX_CMD  = 16'h6040;
  localparam logic [15:0] PPSH_IDX_OPT  = 16'h60f2;

  // command word bit positions
  localparam int PPSH_CW_SWITCH_ON   = 0;
  localparam int PPSH_CW_VOLT_ALLOW  = 1;
  localparam int PPSH_CW_FAST_STOP_N = 2;
  localparam int PPSH_CW_OP_ALLOW    = 3;
  localparam int PPSH_CW_NEW_SETPT   = 4;
  localparam int PPSH_CW_CHG_IMM     = 5;
  localparam int PPSH_CW_ABS_REL     = 6;
  localparam int PPSH_CW_FAULT_CLEAR = 7;
  localparam int PPSH_CW_HALT        = 8;
  localparam int PPSH_CW_CHG_ON_SP   = 9;

  // option word field positions
  localparam int PPSH_OPT_REL_LO  = 0;
  localparam int PPSH_OPT_CIO_LO  = 2;
  localparam int PPSH_OPT_RRO_LO  = 4;
  localparam int PPSH_OPT_VEND_LO = 12;

  // relative reference selections
  localparam logic [1:0] PPSH_REL_PREV   = 2'h0;
  localparam logic [1:0] PPSH_REL_DEMAND = 2'h1;
  localparam logic [1:0] PPSH_REL_ACTUAL = 2'h2;

  // reset values
  localparam logic [15:0] PPSH_WORD_RST = 16'h0000;
  localparam logic [31:0] PPSH_POS_RST  = 32'h0000_0000;

  // minimum gap between starts, in us, and its cycle count at 100 MHz
  localparam int PPSH_START_GAP_US  = 2000;
  localparam int PPSH_CLK_MHZ       = 100;
  localparam int PPSH_START_GAP_CYC = PPSH_START_GAP_US * PPSH_CLK_MHZ;

  // decoded command word
  typedef struct packed {
    logic switch_on;
    logic voltage_allow;
    logic fast_stop_n;
    logic operation_allow;
    logic fault_clear;
    logic halt;
  } ppsh_cmd_t;

  // one positioning task
  typedef struct packed {
    logic [31:0] target;      // resolved absolute target
    logic [31:0] velocity;    // profile velocity
    logic        chg_imm;     // immediate-change bit
    logic        chg_on_sp;   // change-on-set-point bit (stored, unused)
    logic [15:0] options;     // option word snapshot
  } ppsh_task_t;

  // whole state of the handler
  typedef struct packed {
    logic [15:0] cmd_word;
    logic [15:0] opt_word;
    logic        trig_prev;
    logic        run_valid;
    ppsh_task_t  run;
    logic        pend_valid;
    ppsh_task_t  pend;
    logic [31:0] last_target;
    logic        have_last;
    logic        start_pulse;
    logic        discard_pulse;
    logic        abort_all;
  } ppsh_state_t;

endpackage : ppsh_pkg

// File: logic/ppsh_handler.sv
// profile position set-point handler: trigger, queue, discard logic
// Summary of operation
// - trigger rising edge latches target and velocity
// - immediate bit 0: queue until current done
// - immediate bit 1: replace running task now
// - abs/rel bit selects absolute or relative target
// - change-on-set-point mode not implemented
// - zero profile velocity discards task
// - software limit wrong direction discards task
// - travel inhibit wrong direction discards task
// - run-inhibit during halt deceleration drops all
// - run-inhibit with opposed buffered task drops all
// - halt stop clears task option settings
// - command word bit decode
// - option word field decode
// - relative reference previous, demand or actual
// - request-response lets device clear trigger
module ppsh_handler (
  // clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // object write port
  input  wire logic                i_obj_wr,
  input  wire logic [15:0]         i_obj_idx,
  input  wire logic [15:0]         i_obj_wdata,
  // object read data
  output logic      [15:0]         o_drive_command_word,
  output logic      [15:0]         o_positioning_options,
  // set-point values and positions
  input  wire logic [31:0]         i_target_pos,
  input  wire logic [31:0]         i_profile_velocity,
  input  wire logic [31:0]         i_pos_demand,
  input  wire logic [31:0]         i_pos_actual,
  // axis conditions
  input  wire logic                i_task_done,
  input  wire logic                i_sw_limit_pos,
  input  wire logic                i_sw_limit_neg,
  input  wire logic                i_inhibit_pos,
  input  wire logic                i_inhibit_neg,
  input  wire logic                i_halt_decel,
  input  wire logic                i_run_inhibit,
  input  wire logic                i_halt_stopped,
  // task out
  output ppsh_pkg::ppsh_cmd_t      o_cmd,
  output ppsh_pkg::ppsh_task_t     o_run_task,
  output logic                     o_run_valid,
  output logic                     o_pend_valid,
  output logic                     o_start,
  output logic                     o_discard,
  output logic                     o_abort_all
);
  import ppsh_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // every command and option field must sit inside its 16-bit word
  if (PPSH_CW_CHG_ON_SP > 15 || PPSH_CW_HALT > 15) begin : g_bad_cmd_layout
    $error("command word field outside the word");
  end
  // the option fields are two bits wide, the vendor field is on top
  if (PPSH_OPT_RRO_LO + 1 >= PPSH_OPT_VEND_LO || PPSH_OPT_VEND_LO > 15) begin : g_bad_opt_layout
    $error("option word fields overlap or overflow");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // direction of travel from a start position to a target
  // the sign of the wrapped difference picks the shorter way round,
  // so a target more than half the range away reads as the other way
  function automatic logic ppsh_moves_pos(input logic [31:0] from, input logic [31:0] to);
    logic [31:0] diff;
    diff = to - from;
    ppsh_moves_pos = ~diff[31];
  endfunction : ppsh_moves_pos

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // one packed struct carries every flip-flop of the handler,
  // so reset and the register stage cannot miss a field
  ppsh_state_t st_reg;   // registered state
  ppsh_state_t st_next;  // next state

  // ------------------------------------------------------------
  // combinational next state
  // ------------------------------------------------------------
  logic        trig_now;   // trigger bit of current word
  logic        trig_edge;  // 0->1 seen this cycle
  logic [31:0] ref_pos;    // relative reference
  logic [31:0] new_tgt;    // resolved target
  logic        dir_pos;    // new task moves positive
  logic        bad;        // new task must be discarded
  logic        opposed;    // pending runs against running
  ppsh_task_t  nt;         // candidate task

  always_comb begin
    st_next = st_reg;
    st_next.start_pulse   = 1'b0;
    st_next.discard_pulse = 1'b0;
    st_next.abort_all     = 1'b0;
    // object writes land first so the edge is seen next cycle
    if (i_obj_wr && i_obj_idx == PPSH_IDX_CMD) begin
      st_next.cmd_word = i_obj_wdata;
    end
    if (i_obj_wr && i_obj_idx == PPSH_IDX_OPT) begin
      st_next.opt_word = i_obj_wdata;
    end
    // edge is taken from the held word, never from the write port,
    // so a write of the same value twice does not re-trigger
    trig_now  = st_reg.cmd_word[PPSH_CW_NEW_SETPT];
    trig_edge = trig_now & ~st_reg.trig_prev;
    st_next.trig_prev = trig_now;
    // relative reference pick
    case (st_reg.opt_word[PPSH_OPT_REL_LO +: 2])
      PPSH_REL_PREV:   ref_pos = st_reg.have_last ? st_reg.last_target : PPSH_POS_RST;
      PPSH_REL_DEMAND: ref_pos = i_pos_demand;
      PPSH_REL_ACTUAL: ref_pos = i_pos_actual;
      default:         ref_pos = PPSH_POS_RST;  // reserved code treated as zero base
    endcase
    // relative targets wrap modulo the position range
    new_tgt = st_reg.cmd_word[PPSH_CW_ABS_REL] ? ref_pos + i_target_pos : i_target_pos;
    // direction judged from where the generator stands now
    dir_pos = ppsh_moves_pos(i_pos_demand, new_tgt);
    // a limit only lets through travel that backs out of it
    bad = (i_profile_velocity == PPSH_POS_RST)
        | (i_sw_limit_pos & dir_pos) | (i_sw_limit_neg & ~dir_pos)
        | (i_inhibit_pos & dir_pos)  | (i_inhibit_neg & ~dir_pos);
    // candidate task, built every cycle, used only on an edge
    nt.target    = new_tgt;
    nt.velocity  = i_profile_velocity;
    nt.chg_imm   = st_reg.cmd_word[PPSH_CW_CHG_IMM];
    nt.chg_on_sp = st_reg.cmd_word[PPSH_CW_CHG_ON_SP];  // stored, never acted on
    nt.options   = st_reg.opt_word;
    // buffered task heading the other way from the running one
    opposed = st_reg.pend_valid && st_reg.run_valid
            && (ppsh_moves_pos(i_pos_demand, st_reg.pend.target)
                != ppsh_moves_pos(i_pos_demand, st_reg.run.target));
    // running task retires; pending one is promoted
    if (st_reg.run_valid && i_task_done) begin
      st_next.run_valid = st_reg.pend_valid;
      st_next.run       = st_reg.pend;
      st_next.pend_valid = 1'b0;
      st_next.start_pulse = st_reg.pend_valid;
    end
    // halt stop wipes the executing task's options
    if (st_reg.run_valid && i_halt_stopped) begin
      st_next.run.chg_imm   = 1'b0;
      st_next.run.chg_on_sp = 1'b0;
      st_next.run.options   = PPSH_WORD_RST;
    end
    // a task retiring in this same cycle with nothing queued leaves the axis idle,
    // so the new task must start rather than wait for a done
    // that will never come
    if (trig_edge) begin
      if (bad) begin
        // refused task leaves running and pending untouched
        st_next.discard_pulse = 1'b1;
      end else if (nt.chg_imm || !st_next.run_valid) begin
        // immediate change or idle axis: start now
        st_next.run       = nt;
        st_next.run_valid = 1'b1;
        st_next.start_pulse = 1'b1;
        st_next.last_target = new_tgt;
        st_next.have_last   = 1'b1;
      end else begin
        // queued behind the running task, overwriting any older one
        st_next.pend       = nt;
        st_next.pend_valid = 1'b1;
        st_next.last_target = new_tgt;
        st_next.have_last   = 1'b1;
      end
    end
    // device clears trigger itself once a start is taken
    if (st_next.start_pulse && st_reg.opt_word[PPSH_OPT_RRO_LO +: 2] != 2'h0) begin
      st_next.cmd_word[PPSH_CW_NEW_SETPT] = 1'b0;
    end
    // run-inhibit during halt deceleration or with an opposed task drops everything, overriding any start
    if (i_run_inhibit && ((i_halt_decel && st_reg.cmd_word[PPSH_CW_HALT]) || opposed)) begin
      st_next.run_valid   = 1'b0;
      st_next.pend_valid  = 1'b0;
      st_next.start_pulse = 1'b0;
      st_next.abort_all   = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // synchronous reset clears every task and the held words
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output comes straight from the state register,
  // so start and discard pulses last exactly one cycle and nothing glitches
  assign o_drive_command_word  = st_reg.cmd_word;
  assign o_positioning_options = st_reg.opt_word;
  assign o_cmd.switch_on       = st_reg.cmd_word[PPSH_CW_SWITCH_ON];
  assign o_cmd.voltage_allow   = st_reg.cmd_word[PPSH_CW_VOLT_ALLOW];
  assign o_cmd.fast_stop_n     = st_reg.cmd_word[PPSH_CW_FAST_STOP_N];
  assign o_cmd.operation_allow = st_reg.cmd_word[PPSH_CW_OP_ALLOW];
  assign o_cmd.fault_clear     = st_reg.cmd_word[PPSH_CW_FAULT_CLEAR];
  assign o_cmd.halt            = st_reg.cmd_word[PPSH_CW_HALT];
  assign o_run_task            = st_reg.run;
  assign o_run_valid           = st_reg.run_valid;
  assign o_pend_valid          = st_reg.pend_valid;
  assign o_start               = st_reg.start_pulse;
  assign o_discard             = st_reg.discard_pulse;
  assign o_abort_all           = st_reg.abort_all;

endmodule : ppsh_handler

// File: verif/ppsh_handler_bench.sv
// self-checking bench for the set-point handler
module ppsh_handler_bench;
  import ppsh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_obj_wr, i_task_done = 1'b0;
  logic        i_sw_limit_pos = 1'b0, i_sw_limit_neg = 1'b0, i_inhibit_pos = 1'b0;
  logic        i_inhibit_neg = 1'b0, i_halt_decel = 1'b0, i_run_inhibit = 1'b0;
  logic        i_halt_stopped = 1'b0, o_run_valid, o_pend_valid, o_start, o_discard, o_abort_all;
  logic [15:0] i_obj_idx, i_obj_wdata, o_drive_command_word, o_positioning_options;
  logic [31:0] i_target_pos, i_profile_velocity, got_t, t;
  logic [31:0] i_pos_demand = 32'h0000_0000, i_pos_actual = 32'h0000_0000;
  ppsh_cmd_t   o_cmd;
  ppsh_task_t  o_run_task;
  int          errors = 0, compares = 0, n_st = 0, n_dc = 0, n_ab = 0, s, d, last_t = 0;
  always #5 i_mclk = ~i_mclk;
  ppsh_handler ppsh_handler_i (.*);
  ppsh_master ppsh_master_i (.i_mclk, .o_wr(i_obj_wr), .o_idx(i_obj_idx), .o_wdata(i_obj_wdata),
    .o_target(i_target_pos), .o_velocity(i_profile_velocity));
  // pulses counted on the falling edge, clear of updates
  always @(negedge i_mclk) begin
    if (o_start === 1'b1) got_t = o_run_task.target;
    n_st += int'(o_start === 1'b1);
    n_dc += int'(o_discard === 1'b1);
    n_ab += int'(o_abort_all === 1'b1);
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) errors++;
    if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
  endtask : cmp
  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // one trigger, then the starts and discards it caused
  task automatic trig(input logic [31:0] tg, v, input logic [15:0] ctl, opt, input int es, ed);
    s = n_st;
    d = n_dc;
    ppsh_master_i.set_point(tg, v, ctl, opt);
    #2;
    cmp(n_st - s, es);
    cmp(n_dc - d, ed);
  endtask : trig
  initial begin
    #50000;
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0000_cb34));
    repeat (8) @(posedge i_mclk);
    {i_rst, i_pos_demand, i_pos_actual} <= {1'b0, 32'h0000_01f4, 32'h0000_02bc};
    // absolute first, then every relative reference, all immediate
    for (int m = 0; m < 5; m++) begin
      t = $urandom_range(900, 1);
      trig(t, 32'h0000_0064, (m != 0) ? 16'h006f : 16'h002f, 16'(m - 1), 1, 0);
      last_t = int'(t) + ((m == 0) ? 0 : (m == 1) ? last_t : (m == 2) ? 500 : (m == 3) ? 700 : 0);
      cmp(got_t, last_t);
      cmp(o_run_task.velocity, 32'h0000_0064);
    end
    // queued tasks wait for completion, the newer one wins
    trig(32'h0000_1388, 32'h0000_0064, 16'h000f, 16'h0000, 0, 0);
    cmp(o_pend_valid, 1);
    trig(32'h0000_1770, 32'h0000_0064, 16'h000f, 16'h0000, 0, 0);
    s = n_st;
    @(posedge i_mclk) i_task_done <= 1'b1;
    @(posedge i_mclk) i_task_done <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #2;
    cmp(n_st - s, 1);
    cmp(got_t, 32'h0000_1770);
    // zero velocity, then the negative travel inhibit and the positive software limit met in the wrong direction
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk) {i_sw_limit_pos, i_inhibit_neg} <= 2'(k);
      trig((k == 1) ? 50 : 7000, (k == 0) ? 0 : 100, 16'h002f, 16'h0003, 0, 1);
    end
    trig(32'h0000_0032, 32'h0000_0064, 16'h002f, 16'h0003, 1, 0);
    @(posedge i_mclk) {i_sw_limit_pos, i_halt_stopped} <= 2'b01;
    @(posedge i_mclk) i_halt_stopped <= 1'b0;
    #2;
    cmp({o_run_task.chg_imm, o_run_task.options}, 0);
    // halt deceleration meeting a run inhibit drops every task
    s = n_ab;
    ppsh_master_i.put(PPSH_IDX_CMD, 16'h010f);
    @(posedge i_mclk) {i_halt_decel, i_run_inhibit} <= 2'b11;
    repeat (3) @(posedge i_mclk);
    #2;
    cmp(n_ab - s > 0, 1);
    cmp(o_run_valid, 0);
    report_and_stop();
  end
endmodule : ppsh_handler_bench

// File: verif/ppsh_master.sv
// network master model writing cyclic process data
module ppsh_master
  import ppsh_pkg::*;
#(
  parameter int GAP_CYC = 8  // start spacing, shortened to keep runs brief
) (
  input  wire logic   i_mclk,
  output logic        o_wr = 1'b0,
  output logic [15:0] o_idx = 16'h0000,
  output logic [15:0] o_wdata = 16'h0000,
  output logic [31:0] o_target = 32'h0000_0000,
  output logic [31:0] o_velocity = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // one write; data turns to its inverse once released
  task automatic put(input logic [15:0] idx, input logic [15:0] dat);
    @(posedge i_mclk) {o_wr, o_idx, o_wdata} <= {1'b1, idx, dat};
    @(posedge i_mclk) {o_wr, o_wdata} <= {1'b0, ~dat};
  endtask : put
  // options, then a trigger pulse; accel settings never written
  task automatic set_point(input logic [31:0] tg, v, input logic [15:0] ctl, opt);
    put(PPSH_IDX_OPT, opt & 16'hfff3);
    {o_target, o_velocity} <= {tg, v};
    put(PPSH_IDX_CMD, ctl | 16'h0010);
    repeat (GAP_CYC) @(posedge i_mclk);
    put(PPSH_IDX_CMD, ctl & 16'hffef);
  endtask : set_point
endmodule : ppsh_master

// File: verif/ppsh_props.sv
// checker on the set-point handler ports
module ppsh_props
  import ppsh_pkg::*;
(
  // clock, reset and object writes
  input wire logic        i_mclk, i_rst, i_obj_wr, i_halt_stopped,
  input wire logic [15:0] i_obj_idx, i_obj_wdata, o_drive_command_word, o_positioning_options,
  // decoded word and task state
  input wire ppsh_cmd_t   o_cmd,
  input wire ppsh_task_t  o_run_task,
  input wire logic        o_run_valid, o_pend_valid, o_start, o_discard, o_abort_all
);
  wire [15:0] cw = o_drive_command_word;  // short alias of the held word
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // trigger bit seen low, then high
  sequence s_rise; !cw[4] ##1 cw[4]; endsequence
  chk_edge_reply: assert property (s_rise |=>
    o_start | o_discard | o_pend_valid | o_abort_all) else $error("edge unanswered");
  chk_start_cause: assert property (o_start && !$past(o_pend_valid) |->
    $past(cw[4]) && !$past(cw[4], 2)) else $error("start without edge");
  chk_start_load: assert property (o_start |-> o_run_valid && o_run_task.velocity != 0)
    else $error("bad start");
  chk_abort_wins: assert property (o_abort_all |-> !o_start)
    else $error("start beside abort");
  chk_abort_clear: assert property (o_abort_all |-> !o_run_valid && !o_pend_valid)
    else $error("abort left a task");
  chk_cmd_decode: assert property (o_cmd == {cw[0], cw[1], cw[2], cw[3], cw[7], cw[8]})
    else $error("command decode wrong");
  chk_opt_write: assert property (i_obj_wr && i_obj_idx == PPSH_IDX_OPT |=>
    o_positioning_options == $past(i_obj_wdata)) else $error("option word lost");
  chk_halt_clear: assert property (i_halt_stopped && o_run_valid ##1 !o_start |->
    o_run_task.chg_imm == 0 && o_run_task.options == 0) else $error("halt kept options");
endmodule : ppsh_props
bind ppsh_handler ppsh_props ppsh_props_i (.*);
